/* File: logic/tcoc_pkg.sv */
// Package with register map, field layout and types of the timer block.
package tcoc_pkg;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_CTL_A   = 8'h80; // Wave control A.
   localparam logic [7:0] IDX_CTL_B   = 8'h81; // Wave control B.
   localparam logic [7:0] IDX_CMP_A   = 8'h82; // Compare value A.
   localparam logic [7:0] IDX_CMP_B   = 8'h83; // Compare value B.
   localparam logic [7:0] IDX_CAP     = 8'h84; // Capture value (TOP).
   localparam logic [7:0] IDX_CNT     = 8'h85; // Count value, read only.
   localparam logic [7:0] IDX_EV_ST   = 8'h86; // Event status, read only.
   localparam logic [7:0] IDX_EV_CLR  = 8'h87; // Event clear, write only.
   localparam logic [7:0] IDX_EV_EN   = 8'h88; // Event enable.
   localparam logic [7:0] IDX_PIN_DIR = 8'h89; // Pin direction bits.
   localparam logic [7:0] IDX_PIN_DAT = 8'h8A; // Port data bits.

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned     MODE_A_LSB = 6;     // Out mode A at 7:6.
   localparam int unsigned     MODE_B_LSB = 4;     // Out mode B at 5:4.
   localparam int unsigned     WGM_HI_LSB = 3;     // Mode bits 3:2 at 4:3.
   localparam int unsigned     CS_LSB     = 0;     // Clock select at 2:0.
   localparam logic [7:0]      CTL_A_MASK = 8'hF3; // Writable bits of A.
   localparam logic [7:0]      CTL_B_MASK = 8'hDF; // Writable bits of B.
   localparam logic [7:0]      CTL_RST    = 8'h00; // Reset of A and B.
   localparam logic [15:0]     CNT_RST    = 16'h0000;
   localparam int unsigned     EV_WRAP    = 0;     // Wrap event bit.
   localparam int unsigned     EV_MATCH_A = 1;     // Match A event bit.
   localparam int unsigned     EV_MATCH_B = 2;     // Match B event bit.
   localparam int unsigned     EV_W       = 3;     // Event bit count.

   // ----------------------------------------------------------------
   // Prescaler masks and fixed TOP values
   // ----------------------------------------------------------------
   localparam logic [9:0]  PRE_M8    = 10'h007; // Divide by 8.
   localparam logic [9:0]  PRE_M64   = 10'h03F; // Divide by 64.
   localparam logic [9:0]  PRE_M256  = 10'h0FF; // Divide by 256.
   localparam logic [9:0]  PRE_M1024 = 10'h3FF; // Divide by 1024.
   localparam logic [15:0] TOP_8     = 16'h00FF;
   localparam logic [15:0] TOP_9     = 16'h01FF;
   localparam logic [15:0] TOP_10    = 16'h03FF;
   localparam logic [15:0] TOP_MAX   = 16'hFFFF;

   // Clock select codes.
   typedef enum logic [2:0] {
      CS_STOP = 3'h0, CS_DIV1 = 3'h1, CS_DIV8 = 3'h2, CS_DIV64 = 3'h3,
      CS_DIV256 = 3'h4, CS_DIV1024 = 3'h5, CS_EXT_F = 3'h6, CS_EXT_R = 3'h7
   } tcoc_cs_t;

   // Waveform class derived from the four mode bits.
   typedef enum logic [1:0] {
      WC_PLAIN = 2'h0, WC_FAST = 2'h1, WC_DUAL = 2'h3
   } tcoc_class_t;

   // Bus handshake states, Gray along idle to answer.
   typedef enum logic {BUS_IDLE = 1'b0, BUS_ANS = 1'b1} tcoc_bus_t;

   // Avalon-MM request from the master.
   typedef struct packed {
      logic [9:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } tcoc_req_t;

endpackage

/* File: logic/tcoc_timer.sv */
// Timer with two compare output channels behind an Avalon-MM slave.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module tcoc_timer #(
   parameter int unsigned CNT_W = 16 // Counter width, fixed by the map.
) (
   input  wire logic              clk_sys_in,          // System clock.
   input  wire logic              rst_b_in,            // Sync reset, low.
   input  wire tcoc_pkg::tcoc_req_t avs_req_in,        // Bus request.
   output logic [31:0]            avs_readdata_out,    // Read data.
   output logic                   avs_waitrequest_out, // Wait, high idle.
   output logic                   wave_out_a_out,      // Pin A level.
   output logic                   wave_out_a_oe_out,   // Pin A enable.
   output logic                   wave_out_b_out,      // Pin B level.
   output logic                   wave_out_b_oe_out,   // Pin B enable.
   output logic                   irq_out              // Interrupt level.
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   // Event width is declared first because the status registers use it.
   localparam int unsigned EV_W_L = tcoc_pkg::EV_W;

   tcoc_pkg::tcoc_bus_t   st_q;       // Bus handshake state.
   logic                  wait_q;     // Waitrequest flop.
   logic [31:0]           rdata_q;    // Read data flop.
   logic [7:0]            ctl_a_q;    // Wave control A.
   logic [7:0]            ctl_b_q;    // Wave control B.
   logic [15:0]           buf_q [2];  // Compare buffers as written.
   logic [15:0]           act_q [2];  // Active compare values.
   logic [15:0]           cap_q;      // Capture value used as TOP.
   logic [15:0]           cnt_q;      // Count value.
   logic                  up_q;       // Counting upward.
   logic [9:0]            pre_q;      // Prescaler.
   logic                  tick_q;     // Timer tick enable.
   logic                  wave_q [2]; // Compare output levels.
   logic                  pin_q [2];  // Pin levels.
   logic                  oe_q [2];   // Pin enables.
   logic [1:0]            dir_q;      // Direction bits.
   logic [1:0]            dat_q;      // Port data bits.
   logic [EV_W_L-1:0]     ev_st_q;    // Sticky event status.
   logic [EV_W_L-1:0]     ev_en_q;    // Event enable.
   logic [EV_W_L-1:0]     ev_set;     // Events this cycle.
   logic                  wr_go;      // Write takes effect.
   logic [7:0]            idx;        // Register index.
   logic [3:0]            wgm;        // Waveform mode.
   logic [1:0]            mode [2];   // Out mode per channel.
   logic                  con [2];    // Channel owns its pin.
   logic                  hit [2];    // Compare match this tick.
   logic [15:0]           top;        // Current TOP.
   tcoc_pkg::tcoc_class_t cls;        // Current waveform class.

   // Width of the map is fixed at 16 bits.
   if (CNT_W != 16) begin : g_chk
      $error("CNT_W must be 16");
   end

   // ----------------------------------------------------------------
   // Decoding functions
   // ----------------------------------------------------------------
   // Class of a waveform mode; reserved mode 13 behaves as plain.
   function automatic tcoc_pkg::tcoc_class_t cls_of(input logic [3:0] m);
      unique case (m)
         4'h5, 4'h6, 4'h7, 4'hE, 4'hF: cls_of = tcoc_pkg::WC_FAST;
         4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB:
            cls_of = tcoc_pkg::WC_DUAL;
         default: cls_of = tcoc_pkg::WC_PLAIN;
      endcase
   endfunction

   // PWM modes in which code 01 toggles channel A.
   function automatic logic tog_ok(input logic [3:0] m);
      tog_ok = (m == 4'hE) || (m == 4'hF) || (m == 4'h9) || (m == 4'hB);
   endfunction

   // Merges written byte lanes into a 16-bit register.
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0]  be);
      merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
   endfunction

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   // Mode bits combine both control registers.
   assign wgm = {ctl_b_q[tcoc_pkg::WGM_HI_LSB+:2], ctl_a_q[1:0]};
   assign cls = cls_of(wgm);
   assign mode[0] = ctl_a_q[tcoc_pkg::MODE_A_LSB+:2];
   assign mode[1] = ctl_a_q[tcoc_pkg::MODE_B_LSB+:2];
   assign idx = avs_req_in.address[9:2];
   assign wr_go = (st_q == tcoc_pkg::BUS_ANS) && avs_req_in.write;

   // TOP follows the mode: fixed, compare A or capture value.
   always_comb
   begin
      unique case (wgm)
         4'h1, 4'h5: top = tcoc_pkg::TOP_8;
         4'h2, 4'h6: top = tcoc_pkg::TOP_9;
         4'h3, 4'h7: top = tcoc_pkg::TOP_10;
         4'h4, 4'h9, 4'hB, 4'hF: top = act_q[0];
         4'h8, 4'hA, 4'hC, 4'hE: top = cap_q;
         default: top = tcoc_pkg::TOP_MAX;
      endcase
   end

   // ----------------------------------------------------------------
   // Avalon-MM slave: one wait cycle, then the answer
   // ----------------------------------------------------------------
   // A request is seen in idle; the next cycle drops waitrequest.
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_b_in)
      begin
         st_q    <= tcoc_pkg::BUS_IDLE;
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end
      else if (st_q == tcoc_pkg::BUS_IDLE)
      begin
         if (avs_req_in.read || avs_req_in.write)
         begin
            st_q   <= tcoc_pkg::BUS_ANS;
            wait_q <= 1'b0;
         end
         // Unmapped and write-only registers read as zero.
         unique case (idx)
            tcoc_pkg::IDX_CTL_A:   rdata_q <= {24'h0, ctl_a_q};
            tcoc_pkg::IDX_CTL_B:   rdata_q <= {24'h0, ctl_b_q};
            tcoc_pkg::IDX_CMP_A:   rdata_q <= {16'h0, buf_q[0]};
            tcoc_pkg::IDX_CMP_B:   rdata_q <= {16'h0, buf_q[1]};
            tcoc_pkg::IDX_CAP:     rdata_q <= {16'h0, cap_q};
            tcoc_pkg::IDX_CNT:     rdata_q <= {16'h0, cnt_q};
            tcoc_pkg::IDX_EV_ST:   rdata_q <= {29'h0, ev_st_q};
            tcoc_pkg::IDX_EV_EN:   rdata_q <= {29'h0, ev_en_q};
            tcoc_pkg::IDX_PIN_DIR: rdata_q <= {30'h0, dir_q};
            tcoc_pkg::IDX_PIN_DAT: rdata_q <= {30'h0, dat_q};
            default:               rdata_q <= 32'h0000_0000;
         endcase
      end
      else
      begin
         st_q   <= tcoc_pkg::BUS_IDLE;
         wait_q <= 1'b1;
      end
   end

   // Control and pin registers; reserved bits stay zero.
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_b_in)
      begin
         ctl_a_q <= tcoc_pkg::CTL_RST;
         ctl_b_q <= tcoc_pkg::CTL_RST;
         cap_q   <= tcoc_pkg::CNT_RST;
         dir_q   <= 2'h0;
         dat_q   <= 2'h0;
         ev_en_q <= 3'h0;
      end
      else if (wr_go && avs_req_in.byteenable[0])
      begin
         unique case (idx)
            tcoc_pkg::IDX_CTL_A:
               ctl_a_q <= avs_req_in.writedata[7:0] & tcoc_pkg::CTL_A_MASK;
            tcoc_pkg::IDX_CTL_B:
               ctl_b_q <= avs_req_in.writedata[7:0] & tcoc_pkg::CTL_B_MASK;
            tcoc_pkg::IDX_PIN_DIR: dir_q   <= avs_req_in.writedata[1:0];
            tcoc_pkg::IDX_PIN_DAT: dat_q   <= avs_req_in.writedata[1:0];
            tcoc_pkg::IDX_EV_EN:   ev_en_q <= avs_req_in.writedata[2:0];
            default: ;
         endcase
      end
      if (rst_b_in && wr_go && idx == tcoc_pkg::IDX_CAP)
      begin
         cap_q <= merge16(cap_q, avs_req_in.writedata,
                          avs_req_in.byteenable);
      end
   end

   // Compare buffers take bus writes.
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_b_in)
      begin
         buf_q[0] <= tcoc_pkg::CNT_RST;
         buf_q[1] <= tcoc_pkg::CNT_RST;
      end
      else if (wr_go && idx == tcoc_pkg::IDX_CMP_A)
      begin
         buf_q[0] <= merge16(buf_q[0], avs_req_in.writedata,
                             avs_req_in.byteenable);
      end
      else if (wr_go && idx == tcoc_pkg::IDX_CMP_B)
      begin
         buf_q[1] <= merge16(buf_q[1], avs_req_in.writedata,
                             avs_req_in.byteenable);
      end
   end

   // ----------------------------------------------------------------
   // Prescaler and tick
   // ----------------------------------------------------------------
   // Free prescaler; the tick is a one-cycle enable.
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_b_in)
      begin
         pre_q  <= 10'h000;
         tick_q <= 1'b0;
      end
      else
      begin
         pre_q <= 10'(pre_q + 10'h001);
         unique case (tcoc_pkg::tcoc_cs_t'(ctl_b_q[2:0]))
            tcoc_pkg::CS_DIV1:    tick_q <= 1'b1;
            tcoc_pkg::CS_DIV8:    tick_q <= &(pre_q[2:0]);
            tcoc_pkg::CS_DIV64:   tick_q <= &(pre_q[5:0]);
            tcoc_pkg::CS_DIV256:  tick_q <= &(pre_q[7:0]);
            tcoc_pkg::CS_DIV1024: tick_q <= &pre_q;
            default:              tick_q <= 1'b0; // Stopped or external.
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Counter and compare update
   // ----------------------------------------------------------------
   // Single slope wraps at TOP; dual slope turns at TOP and BOTTOM.
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_b_in)
      begin
         cnt_q <= tcoc_pkg::CNT_RST;
         up_q  <= 1'b1;
      end
      else if (tick_q)
      begin
         if (cls == tcoc_pkg::WC_DUAL)
         begin
            if (up_q && cnt_q >= top)
            begin
               up_q  <= 1'b0;
               cnt_q <= 16'(cnt_q - 16'h0001);
            end
            else if (!up_q && cnt_q == 16'h0000)
            begin
               up_q  <= 1'b1;
               cnt_q <= 16'h0001;
            end
            else
            begin
               cnt_q <= up_q ? 16'(cnt_q + 16'h0001) : 16'(cnt_q - 16'h0001);
            end
         end
         else
         begin
            up_q  <= 1'b1;
            cnt_q <= (cnt_q >= top) ? 16'h0000 : 16'(cnt_q + 16'h0001);
         end
      end
   end

   // Plain modes write through; PWM modes copy at TOP or BOTTOM.
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_b_in)
      begin
         act_q[0] <= tcoc_pkg::CNT_RST;
         act_q[1] <= tcoc_pkg::CNT_RST;
      end
      else if (cls == tcoc_pkg::WC_PLAIN)
      begin
         act_q[0] <= buf_q[0];
         act_q[1] <= buf_q[1];
      end
      else if (tick_q && ((wgm inside {4'h1, 4'h2, 4'h3, 4'hA, 4'hB})
                          ? (cnt_q == top && up_q)
                          : (cnt_q == 16'h0000)))
      begin
         act_q[0] <= buf_q[0];
         act_q[1] <= buf_q[1];
      end
   end

   // ----------------------------------------------------------------
   // Compare output channels
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 2; g++) begin : g_ch
      assign hit[g] = tick_q && (cnt_q == act_q[g]);
      // Code 01 in PWM classes owns the pin only on A in toggle modes.
      assign con[g] = (mode[g] != 2'b00) && !(mode[g] == 2'b01 &&
                      cls != tcoc_pkg::WC_PLAIN &&
                      !(g == 0 && tog_ok(wgm)));

      // Output level changes only on tick cycles.
      always_ff @(posedge clk_sys_in)
      begin
         if (!rst_b_in)
         begin
            wave_q[g] <= 1'b0;
         end
         else if (tick_q && mode[g] == 2'b01)
         begin
            if (hit[g] && con[g])
               wave_q[g] <= !wave_q[g];
         end
         else if (tick_q && mode[g][1] && cls == tcoc_pkg::WC_PLAIN)
         begin
            if (hit[g])
               wave_q[g] <= mode[g][0];
         end
         else if (tick_q && mode[g][1] && cls == tcoc_pkg::WC_FAST)
         begin
            if (hit[g] && act_q[g] != top)
               wave_q[g] <= mode[g][0];
            else if (cnt_q == 16'h0000)
               wave_q[g] <= !mode[g][0];
         end
         else if (tick_q && mode[g][1])
         begin
            if (act_q[g] == 16'h0000)
               wave_q[g] <= mode[g][0];
            else if (act_q[g] == top)
               wave_q[g] <= !mode[g][0];
            else if (hit[g])
               wave_q[g] <= up_q ? mode[g][0] : !mode[g][0];
         end
      end

      // Pin follows the channel when owned, else port data.
      always_ff @(posedge clk_sys_in)
      begin
         if (!rst_b_in)
         begin
            pin_q[g] <= 1'b0;
            oe_q[g]  <= 1'b0;
         end
         else
         begin
            pin_q[g] <= con[g] ? wave_q[g] : dat_q[g];
            oe_q[g]  <= dir_q[g];
         end
      end
   end

   // ----------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------
   // Wrap at BOTTOM in dual slope, at TOP in fast, at MAX otherwise.
   always_comb
   begin
      ev_set = 3'h0;
      ev_set[tcoc_pkg::EV_MATCH_A] = hit[0];
      ev_set[tcoc_pkg::EV_MATCH_B] = hit[1];
      unique case (cls)
         tcoc_pkg::WC_DUAL:
            ev_set[tcoc_pkg::EV_WRAP] = tick_q && !up_q && cnt_q == 16'h0;
         tcoc_pkg::WC_FAST:
            ev_set[tcoc_pkg::EV_WRAP] = tick_q && cnt_q == top;
         default:
            ev_set[tcoc_pkg::EV_WRAP] = tick_q && cnt_q == tcoc_pkg::TOP_MAX;
      endcase
   end

   // Sticky status; a new event wins over a clear in the same cycle.
   always_ff @(posedge clk_sys_in)
   begin
      if (!rst_b_in)
      begin
         ev_st_q <= 3'h0;
         irq_out <= 1'b0;
      end
      else
      begin
         if (wr_go && idx == tcoc_pkg::IDX_EV_CLR && avs_req_in.byteenable[0])
            ev_st_q <= (ev_st_q & ~avs_req_in.writedata[2:0]) | ev_set;
         else
            ev_st_q <= ev_st_q | ev_set;
         irq_out <= |(ev_st_q & ev_en_q);
      end
   end

   assign avs_readdata_out    = rdata_q;
   assign avs_waitrequest_out = wait_q;
   assign wave_out_a_out      = pin_q[0];
   assign wave_out_a_oe_out   = oe_q[0];
   assign wave_out_b_out      = pin_q[1];
   assign wave_out_b_oe_out   = oe_q[1];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_req;
      st_q == tcoc_pkg::BUS_IDLE && (avs_req_in.read || avs_req_in.write);
   endsequence
   sequence s_ans;
      !wait_q ##1 wait_q;
   endsequence

   AST_BUS_ANS: assert property (@(posedge clk_sys_in) disable iff
      (!rst_b_in) s_req |=> s_ans) else $error("Bus answer late");
   AST_TICK_DIV1: assert property (@(posedge clk_sys_in) disable iff
      (!rst_b_in) $past(ctl_b_q[2:0]) == 3'h1 |-> tick_q)
      else $error("Tick missing at divide by one");
   AST_CNT_HOLD: assert property (@(posedge clk_sys_in) disable iff
      (!rst_b_in) !tick_q |=> $stable(cnt_q))
      else $error("Counter moved without tick");
   AST_WAVE_HOLD: assert property (@(posedge clk_sys_in) disable iff
      (!rst_b_in) !tick_q |=> $stable(wave_q[0]) && $stable(wave_q[1]))
      else $error("Output moved without tick");
   AST_ROUTE: assert property (@(posedge clk_sys_in) disable iff
      (!rst_b_in) con[0] |=> pin_q[0] == $past(wave_q[0]))
      else $error("Owned pin not following output");
   AST_OE: assert property (@(posedge clk_sys_in) disable iff
      (!rst_b_in) !dir_q[1] |=> !oe_q[1])
      else $error("Driver enabled without direction bit");
   AST_DUAL_LOW: assert property (@(posedge clk_sys_in) disable iff
      (!rst_b_in) cls == tcoc_pkg::WC_DUAL && mode[0] == 2'b10 &&
      act_q[0] == 16'h0 && tick_q |=> !wave_q[0])
      else $error("Output not low at BOTTOM compare");
   AST_TOGGLE: assert property (@(posedge clk_sys_in) disable iff
      (!rst_b_in) wgm == 4'h9 && mode[0] == 2'b01 && hit[0]
      |=> wave_q[0] != $past(wave_q[0])) else $error("No toggle on match");
   AST_PLAIN_CLR: assert property (@(posedge clk_sys_in) disable iff
      (!rst_b_in) cls == tcoc_pkg::WC_PLAIN && mode[1] == 2'b10 && hit[1]
      |=> !wave_q[1]) else $error("Match did not clear output");
   AST_FAST_DIS: assert property (@(posedge clk_sys_in) disable iff
      (!rst_b_in) cls == tcoc_pkg::WC_FAST && mode[1] == 2'b01 |-> !con[1])
      else $error("Channel B owns pin in fast code 01");
   AST_PFC_UPD: assert property (@(posedge clk_sys_in) disable iff
      (!rst_b_in) wgm == 4'h8 && tick_q && cnt_q == 16'h0
      |=> act_q[1] == $past(buf_q[1])) else $error("No copy at BOTTOM");

endmodule

/* File: test/tcoc_load.sv */
// Load model on the two compare pins, with pull-downs on both pads.
`timescale 1ns/1ps
module tcoc_load (
   input  wire logic       lvl_a_in, // Pin A level from the block.
   input  wire logic       oe_a_in,  // Pin A driver enable.
   input  wire logic       lvl_b_in, // Pin B level from the block.
   input  wire logic       oe_b_in,  // Pin B driver enable.
   output logic [1:0]      pad_out   // Pad levels, bit 0 is pin A.
);
   // An undriven pad falls to the pull-down level, never the last value.
   assign pad_out = {oe_b_in ? lvl_b_in : 1'b0,
                     oe_a_in ? lvl_a_in : 1'b0};
endmodule

/* File: test/tcoc_timer_tb_top.sv */
// Self-checking bench for the compare output timer block.
`timescale 1ns/1ps
module tcoc_timer_tb_top;
   logic                clk_sys_in = 1'b0; // System clock.
   logic                rst_b_in   = 1'b0; // Reset, active low.
   tcoc_pkg::tcoc_req_t req_q      = '0;   // Bus request to the block.
   logic [31:0]         rdata;             // Read data.
   logic                wreq;              // Wait request.
   logic                pa, oa, pb, ob;    // Pin levels and enables.
   logic                irq;               // Interrupt level.
   logic [1:0]          pad;               // Pad levels at the load.
   logic [31:0]         v;                 // Last read value.
   int                  n_fail    = 0;     // Mismatch count.
   int                  cmp_count = 0;     // Comparison count.
   // The clock toggles every half period of 10 ns.
   always #10 clk_sys_in = ~clk_sys_in;
   tcoc_timer DUT (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
      .avs_req_in(req_q), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .wave_out_a_out(pa),
      .wave_out_a_oe_out(oa), .wave_out_b_out(pb),
      .wave_out_b_oe_out(ob), .irq_out(irq));
   tcoc_load LOAD (.lvl_a_in(pa), .oe_a_in(oa), .lvl_b_in(pb),
      .oe_b_in(ob), .pad_out(pad));
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Compares one value and reports a mismatch at once.
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One bus transfer, held until wait request is sampled low.
   task automatic bus(input logic [7:0] idx, input logic wr,
                      input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_sys_in);
      req_q <= '{{idx, 2'b00}, ~wr, wr, d, 4'hF};
      // Wait request low ends this wait, the watchdog only a hang; the edge count is checked after.
      do
      begin
         @(posedge clk_sys_in);
         k++;
      end
      while (wreq !== 1'b0);
      v = rdata;
      req_q <= '0;
      // The slave answers after exactly one wait cycle.
      chk("bus wait edges", 32'h2, k);
   endtask
   // Counts the cycles in which one pad is high over a span of cycles.
   task automatic hi_count(input int n, input int b, output int c);
      c = 0;
      repeat (n)
      begin
         @(posedge clk_sys_in);
         if (pad[b] === 1'b1)
            c++;
      end
   endtask
   // Reset value, reserved bits and an unmapped place.
   task automatic t_regs;
      bus(tcoc_pkg::IDX_CTL_A, 1'b0, 32'h0);
      chk("ctl_a reset", 32'h0000_0000, v);
      bus(tcoc_pkg::IDX_CTL_A, 1'b1, 32'h0000_00FF);
      bus(tcoc_pkg::IDX_CTL_A, 1'b0, 32'h0);
      chk("ctl_a fields", 32'h0000_00F3, v);
      bus(8'h8F, 1'b0, 32'h0);
      chk("unmapped", 32'h0000_0000, v);
   endtask
   // Clear-on-match mode: set, clear, release and direction of pin A.
   task automatic t_plain;
      bus(tcoc_pkg::IDX_CMP_A, 1'b1, 32'h0000_0003);
      bus(tcoc_pkg::IDX_PIN_DIR, 1'b1, 32'h0000_0003);
      bus(tcoc_pkg::IDX_CTL_B, 1'b1, 32'h0000_0009);
      bus(tcoc_pkg::IDX_CTL_A, 1'b1, 32'h0000_00C0);
      repeat (30) @(posedge clk_sys_in);
      chk("pin a set", 32'h1, {31'h0, pad[0]});
      bus(tcoc_pkg::IDX_CTL_A, 1'b1, 32'h0000_0080);
      repeat (30) @(posedge clk_sys_in);
      chk("pin a clear", 32'h0, {31'h0, pad[0]});
      bus(tcoc_pkg::IDX_PIN_DAT, 1'b1, 32'h0000_0001);
      bus(tcoc_pkg::IDX_CTL_A, 1'b1, 32'h0000_0000);
      repeat (3) @(posedge clk_sys_in);
      chk("port data", 32'h1, {31'h0, pad[0]});
      bus(tcoc_pkg::IDX_PIN_DIR, 1'b1, 32'h0000_0000);
      repeat (3) @(posedge clk_sys_in);
      chk("dir off", 32'h0, {31'h0, pad[0]});
   endtask
   // Match A event raises, is enabled to the interrupt and is cleared.
   task automatic t_irq;
      bus(tcoc_pkg::IDX_EV_EN, 1'b1, 32'h0000_0002);
      repeat (3) @(posedge clk_sys_in);
      chk("irq on", 32'h1, {31'h0, irq});
      bus(tcoc_pkg::IDX_CTL_B, 1'b1, 32'h0000_0000);
      bus(tcoc_pkg::IDX_EV_CLR, 1'b1, 32'h0000_0007);
      bus(tcoc_pkg::IDX_EV_ST, 1'b0, 32'h0);
      chk("status cleared", 32'h0000_0000, v);
      chk("irq off", 32'h0, {31'h0, irq});
   endtask
   // Dual slope with compare at BOTTOM and at TOP holds fixed levels.
   task automatic t_dual;
      bus(tcoc_pkg::IDX_CAP, 1'b1, 32'h0000_0008);
      bus(tcoc_pkg::IDX_CMP_A, 1'b1, 32'h0000_0000);
      bus(tcoc_pkg::IDX_CMP_B, 1'b1, 32'h0000_0008);
      bus(tcoc_pkg::IDX_PIN_DIR, 1'b1, 32'h0000_0003);
      bus(tcoc_pkg::IDX_CTL_A, 1'b1, 32'h0000_00E0);
      bus(tcoc_pkg::IDX_CTL_B, 1'b1, 32'h0000_0011);
      repeat (40) @(posedge clk_sys_in);
      repeat (8)
      begin
         repeat (5) @(posedge clk_sys_in);
         chk("dual pads", 32'h3, {30'h0, pad});
      end
   endtask
   // Toggle square wave at two tick rates, then fast PWM with TOP compare.
   task automatic t_wave;
      int c;
      // Mode 9 with TOP 4: one toggle per 8 ticks, high half the time.
      bus(tcoc_pkg::IDX_CMP_A, 1'b1, 32'h0000_0004);
      bus(tcoc_pkg::IDX_CTL_A, 1'b1, 32'h0000_0051);
      repeat (40) @(posedge clk_sys_in);
      hi_count(32, 0, c);
      chk("toggle duty", 32'h10, c);
      chk("pin b code 01", 32'h0, {31'h0, pad[1]});
      // Divide by 8 stretches each half period to 64 cycles.
      bus(tcoc_pkg::IDX_CTL_B, 1'b1, 32'h0000_0012);
      repeat (80) @(posedge clk_sys_in);
      hi_count(256, 0, c);
      chk("toggle duty div 8", 32'h80, c);
      // Mode 14, TOP 8: A high 4 of 9 ticks, B at TOP never set.
      bus(tcoc_pkg::IDX_CTL_B, 1'b1, 32'h0000_0019);
      bus(tcoc_pkg::IDX_CTL_A, 1'b1, 32'h0000_00B2);
      repeat (30) @(posedge clk_sys_in);
      hi_count(36, 0, c);
      chk("fast duty a", 32'h10, c);
      hi_count(36, 1, c);
      chk("fast top b", 32'h0, c);
   endtask
   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      #200us;
      n_fail++;
      report_and_stop();
   end
   // Main sequence: reset for 20 cycles, then the scenarios.
   initial
   begin
      repeat (20) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      t_regs();
      t_plain();
      t_irq();
      t_dual();
      t_wave();
      report_and_stop();
   end
endmodule
